// ==== src/cafu_filter_unit.sv ====
module cafu_filter_unit #(
   parameter int CNT_W = 16
) (
   input  logic                          clk,
   input  logic                          arst_n,
   input  logic                          ce,
   // Register bus
   input  logic                          awvalid,
   output logic                          awready,
   input  logic [cafu_pkg::ADDR_W-1:0]   awaddr,
   input  logic                          wvalid,
   output logic                          wready,
   input  logic [31:0]                   wdata,
   input  logic [3:0]                    wstrb,
   output logic                          bvalid,
   input  logic                          bready,
   output logic [1:0]                    bresp,
   input  logic                          arvalid,
   output logic                          arready,
   input  logic [cafu_pkg::ADDR_W-1:0]   araddr,
   output logic                          rvalid,
   input  logic                          rready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   // Controller mode
   input  logic [2:0]                    operatingModeStatus,
   // Assembly buffer side
   input  logic                          asmValid,
   output logic                          asmReady,
   input  logic [cafu_pkg::SID_W-1:0]    asmStdId,
   input  logic [cafu_pkg::EID_W-1:0]    asmExtId,
   input  logic                          asmIsExt,
   // Receive FIFO side
   input  logic [cafu_pkg::NUM_FILT-1:0] fifoFull,
   output logic                          storeValid,
   output logic [cafu_pkg::DEST_W-1:0]   storeFifo,
   output logic [cafu_pkg::IDX_W-1:0]    filterHitIndex,
   output logic                          dropValid
);
   import cafu_pkg::*;

   typedef struct packed {
      cafu_state_t                  st;
      logic [IDX_W-1:0]             idx;
      logic [NUM_FILT-1:0][7:0]     ctl;
      logic [NUM_FILT-1:0][31:0]    val;
      logic [NUM_MASK-1:0][31:0]    mask;
      logic [NUM_FILT-1:0]          pendOff;
      logic [SID_W-1:0]             standard_id_part;
      logic [EID_W-1:0]             extended_id_part;
      logic                         ext;
      logic                         awHave;
      logic [ADDR_W-1:0]            awAddr;
      logic                         wHave;
      logic [31:0]                  wData;
      logic [3:0]                   wStrb;
      logic                         bValid;
      logic [1:0]                   bResp;
      logic                         rValid;
      logic [31:0]                  rData;
      logic [1:0]                   rResp;
      logic                         storeValid;
      logic [DEST_W-1:0]            storeFifo;
      logic [IDX_W-1:0]             hitIdx;
      logic                         dropValid;
      logic                         lastOk;
      logic [CNT_W-1:0]             accCnt;
      logic [CNT_W-1:0]             dropCnt;
   } cafu_regs_t;

   cafu_regs_t           r_r;
   cafu_regs_t           r_nxt;
   cafu_region_t         wrReg;
   cafu_region_t         rdReg;
   logic                 wrGo;
   logic                 modeOk;
   logic                 busy;
   logic [IDX_W-1:0]     wrF;
   logic [MSEL_W-1:0]    wrM;
   logic [31:0]          strbMask;
   logic [NUM_FILT-1:0]  onVec;
   logic [NUM_MASK-1:0]  maskUse;
   logic [7:0]           curCtl;
   logic [31:0]          curVal;
   logic [31:0]          curMask;
   logic                 sidOk;
   logic                 eidOk;
   logic                 typOk;
   logic                 hitNow;
   logic [DEST_W-1:0]    hitDest;
   logic [ADDR_W-1:0]    valOff;
   int                   f;

   // Map a byte address onto a register region
   function automatic cafu_region_t regionOf(input logic [ADDR_W-1:0] a);
      cafu_region_t rg;
      rg = RG_NONE;
      if (a < ADDR_CTL_END) begin
         rg = RG_CTL;
      end else if (a >= ADDR_VAL && a < ADDR_MASK) begin
         rg = RG_VAL;
      end else if (a >= ADDR_MASK && a < ADDR_STAT) begin
         rg = RG_MASK;
      end else if (a[7:2] == ADDR_STAT[7:2]) begin
         rg = RG_STAT;
      end else if (a[7:2] == ADDR_ACC[7:2]) begin
         rg = RG_ACC;
      end else if (a[7:2] == ADDR_DROP[7:2]) begin
         rg = RG_DROP;
      end
      return rg;
   endfunction

   // Bus handshakes stall while the clock enable is low
   assign awready = ce && !r_r.awHave && !r_r.bValid;
   assign wready  = ce && !r_r.wHave && !r_r.bValid;
   assign arready = ce && !r_r.rValid;
   assign asmReady = ce && (r_r.st == ST_IDLE);
   assign bvalid  = r_r.bValid;
   assign bresp   = r_r.bResp;
   assign rvalid  = r_r.rValid;
   assign rdata   = r_r.rData;
   assign rresp   = r_r.rResp;
   assign storeValid     = r_r.storeValid;
   assign storeFifo      = r_r.storeFifo;
   assign filterHitIndex = r_r.hitIdx;
   assign dropValid      = r_r.dropValid;

   // Write decode of the captured address and data
   assign wrGo   = r_r.awHave && r_r.wHave && !r_r.bValid;
   assign wrReg  = regionOf(r_r.awAddr);
   assign rdReg  = regionOf(araddr);
   assign valOff = r_r.awAddr - ADDR_VAL;
   assign wrF    = valOff[6:2];
   assign wrM    = r_r.awAddr[3:2];
   assign busy   = (r_r.st != ST_IDLE);
   assign strbMask = {{8{r_r.wStrb[3]}}, {8{r_r.wStrb[2]}},
                      {8{r_r.wStrb[1]}}, {8{r_r.wStrb[0]}}};
   assign modeOk = (operatingModeStatus == MODE_CONFIG) ||
                   (operatingModeStatus == MODE_NORMAL) ||
                   (operatingModeStatus == MODE_DISABLE);

   // Enabled filters and the masks they hold in use
   always_comb begin
      maskUse = '0;
      for (int i = 0; i < NUM_FILT; i++) begin
         onVec[i] = r_r.ctl[i][CTL_ON_BIT];
         if (onVec[i]) begin
            maskUse[r_r.ctl[i][CTL_MSEL_LSB +: MSEL_W]] = 1'b1;
         end
      end
   end

   // Compare the held frame with the filter under scan
   assign curCtl  = r_r.ctl[r_r.idx];
   assign curVal  = r_r.val[r_r.idx];
   assign curMask = r_r.mask[curCtl[CTL_MSEL_LSB +: MSEL_W]];
   assign hitDest = curCtl[CTL_DEST_LSB +: DEST_W];
   assign sidOk = ((curVal[VAL_SID_LSB +: SID_W] ^ r_r.standard_id_part) &
                   curMask[VAL_SID_LSB +: SID_W]) == '0;
   assign eidOk = !r_r.ext ||
                  ((curVal[VAL_EID_LSB +: EID_W] ^ r_r.extended_id_part) &
                   curMask[VAL_EID_LSB +: EID_W]) == '0;
   assign typOk = !curMask[VAL_EXT_BIT] ||
                  (curVal[VAL_EXT_BIT] == r_r.ext);
   assign hitNow = curCtl[CTL_ON_BIT] && sidOk && eidOk && typOk &&
                   !fifoFull[hitDest];

   // Next state of the whole unit
   always_comb begin
      r_nxt = r_r;
      f = 0;
      r_nxt.storeValid = 1'b0;
      r_nxt.dropValid  = 1'b0;
      // Address and data are taken independently
      if (awvalid && awready) begin
         r_nxt.awHave = 1'b1;
         r_nxt.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         r_nxt.wHave = 1'b1;
         r_nxt.wData = wdata;
         r_nxt.wStrb = wstrb;
      end
      if (r_r.bValid && bready) begin
         r_nxt.bValid = 1'b0;
      end
      // Perform a write once both halves are held
      if (wrGo) begin
         r_nxt.awHave = 1'b0;
         r_nxt.wHave  = 1'b0;
         r_nxt.bValid = 1'b1;
         r_nxt.bResp  = RESP_OKAY;
         case (wrReg)
            RG_CTL: begin
               for (int b = 0; b < 4; b++) begin
                  f = 4 * int'(r_r.awAddr[4:2]) + b;
                  if (r_r.wStrb[b] && modeOk) begin
                     if (busy && r_r.ctl[f][CTL_ON_BIT] &&
                         !r_r.wData[8*b+CTL_ON_BIT]) begin
                        // Off request held until the scan ends
                        r_nxt.ctl[f] = r_r.wData[8*b +: 8] |
                                       8'h80;
                        r_nxt.pendOff[f] = 1'b1;
                     end else begin
                        r_nxt.ctl[f] = r_r.wData[8*b +: 8];
                        r_nxt.pendOff[f] = 1'b0;
                     end
                  end
               end
            end
            RG_VAL: begin
               if (modeOk && !r_r.ctl[wrF][CTL_ON_BIT]) begin
                  r_nxt.val[wrF] = ((r_r.val[wrF] & ~strbMask) |
                                    (r_r.wData & strbMask)) & VAL_USED;
               end
            end
            RG_MASK: begin
               if (operatingModeStatus == MODE_CONFIG &&
                   !maskUse[wrM]) begin
                  r_nxt.mask[wrM] = ((r_r.mask[wrM] & ~strbMask) |
                                     (r_r.wData & strbMask)) & VAL_USED;
               end
            end
            RG_STAT, RG_ACC, RG_DROP: begin
               r_nxt.bResp = RESP_OKAY;
            end
            default: begin
               r_nxt.bResp = RESP_SLVERR;
            end
         endcase
      end
      // Read answer one cycle after the address is taken
      if (r_r.rValid && rready) begin
         r_nxt.rValid = 1'b0;
      end
      if (arvalid && arready) begin
         r_nxt.rValid = 1'b1;
         r_nxt.rResp  = RESP_OKAY;
         r_nxt.rData  = '0;
         case (rdReg)
            RG_CTL: begin
               r_nxt.rData = r_r.ctl[{araddr[4:2], 2'b00} +: 4];
            end
            RG_VAL: begin
               r_nxt.rData = r_r.val[araddr[6:2] - 5'h10];
            end
            RG_MASK: begin
               r_nxt.rData = r_r.mask[araddr[3:2]];
            end
            RG_STAT: begin
               r_nxt.rData[STAT_DEST_LSB +: DEST_W] = r_r.storeFifo;
               r_nxt.rData[STAT_HIT_LSB +: IDX_W]   = r_r.hitIdx;
               r_nxt.rData[STAT_OK_BIT]             = r_r.lastOk;
               r_nxt.rData[STAT_BUSY_BIT]           = busy;
               r_nxt.rData[STAT_MODE_LSB +: 3]      = operatingModeStatus;
            end
            RG_ACC: begin
               r_nxt.rData[CNT_W-1:0] = r_r.accCnt;
            end
            RG_DROP: begin
               r_nxt.rData[CNT_W-1:0] = r_r.dropCnt;
            end
            default: begin
               r_nxt.rResp = RESP_SLVERR;
            end
         endcase
      end
      // Filtering sequence, after the register writes so that
      // a deferred off written in the last cycle is applied at once
      case (r_r.st)
         ST_IDLE: begin
            if (asmValid && asmReady) begin
               r_nxt.standard_id_part = asmStdId;
               r_nxt.extended_id_part = asmExtId;
               r_nxt.ext = asmIsExt;
               r_nxt.idx = '0;
               r_nxt.st  = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (hitNow) begin
               // Lowest eligible filter wins the frame
               r_nxt.storeValid = 1'b1;
               r_nxt.storeFifo  = hitDest;
               r_nxt.hitIdx     = r_r.idx;
               r_nxt.lastOk     = 1'b1;
               r_nxt.accCnt     = r_r.accCnt + 1'b1;
               r_nxt.st         = ST_DONE;
            end else if (r_r.idx == IDX_W'(NUM_FILT - 1)) begin
               r_nxt.dropValid = 1'b1;
               r_nxt.lastOk    = 1'b0;
               r_nxt.dropCnt   = r_r.dropCnt + 1'b1;
               r_nxt.st        = ST_DONE;
            end else begin
               r_nxt.idx = r_r.idx + 1'b1;
            end
         end
         ST_DONE: begin
            // Apply off requests held during the scan
            for (int i = 0; i < NUM_FILT; i++) begin
               if (r_nxt.pendOff[i]) begin
                  r_nxt.ctl[i][CTL_ON_BIT] = 1'b0;
               end
            end
            r_nxt.pendOff = '0;
            r_nxt.st      = ST_IDLE;
         end
         default: begin
            r_nxt.st = ST_IDLE;
         end
      endcase
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_r <= '0;
      end else if (ce) begin
         r_r <= r_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_scan_ends: assert property (
      ce && asmValid && asmReady |-> ##[2:33] (storeValid || dropValid))
      else $error("scan did not finish within 32 filters");

   a_store_dest: assert property (
      ce && r_r.st == ST_SCAN && hitNow |=>
         storeValid && storeFifo == $past(hitDest) &&
         filterHitIndex == $past(r_r.idx))
      else $error("hit not stored to its FIFO with its index");

   a_one_result: assert property (
      !(storeValid && dropValid))
      else $error("frame both stored and dropped");

   a_skip_full: assert property (
      ce && r_r.st == ST_SCAN && !hitNow && r_r.idx != 5'h1f |=>
         !storeValid && r_r.idx == $past(r_r.idx) + 5'h01)
      else $error("scan did not move to the next filter");

   a_drop_none: assert property (
      ce && r_r.st == ST_SCAN && !hitNow && r_r.idx == 5'h1f |=>
         dropValid && !storeValid)
      else $error("unmatched frame not discarded");

   a_val_locked: assert property (
      ce && wrGo && wrReg == RG_VAL && r_r.ctl[wrF][CTL_ON_BIT] |=>
         r_r.val == $past(r_r.val))
      else $error("enabled filter value changed");

   a_mask_mode: assert property (
      $changed(r_r.mask) |-> $past(operatingModeStatus) == MODE_CONFIG)
      else $error("mask changed outside configuration mode");

   a_mask_inuse: assert property (
      ce && wrGo && wrReg == RG_MASK && maskUse[wrM] |=>
         $stable(r_r.mask))
      else $error("mask in use was modified");

   a_pend_busy: assert property (
      r_r.pendOff != '0 |-> busy && (r_r.pendOff & ~onVec) == '0)
      else $error("pending off outside scan or bit reads clear");

   a_ctl_mode: assert property (
      ce && wrGo && wrReg == RG_CTL && !modeOk |=>
         r_r.ctl == $past(r_r.ctl))
      else $error("filter control written in a locked mode");

endmodule

// ==== src/cafu_pkg.sv ====
// Notes on behaviour
// - Thirty-two acceptance filters share four identifier mask registers.
// - Each filter has an on bit, two-bit mask choice, five-bit FIFO select.
// - Setting a filter's on bit enables it; clearing it disables it.
// - After reception filters are stepped through from filter 0 until one accepts, XOR compare under mask.
// - Mask bit one compares that identifier bit; zero ignores it.
// - An enabled matching filter sends the frame to its selected FIFO.
// - Any filter may name any FIFO; filters may share one FIFO.
// - The accepting filter's index is stored with the frame.
// - One frame goes to at most one FIFO; lowest matching filter wins.
// - If the winner's FIFO is full, the next matching filter with room wins.
// - Identifiers are 11-bit standard or 29-bit extended; filters hold both parts.
// - Filter extended-select bit 19 targets extended frames when set.
// - Mask type-match bit 19 clear accepts either frame type; extended part compared only for extended frames.
// - Type-match set requires frame type equal filter's extended-select bit.
// - Filter settings change only in configuration, normal or disable mode.
// - Clearing an on bit during filtering is deferred; bit reads set meanwhile.
// - A frame hitting a pending-off filter is still stored there first.
// - Writes to a filter's value register are ignored while it is enabled.
// - A mask cannot change while any enabled filter selects it.
// - Mask registers accept writes only in configuration mode.
package cafu_pkg;
   // Sizes
   localparam int NUM_FILT = 32;
   localparam int NUM_MASK = 4;
   localparam int DEST_W   = 5;
   localparam int IDX_W    = 5;
   localparam int MSEL_W   = 2;
   localparam int SID_W    = 11;
   localparam int EID_W    = 18;
   localparam int ADDR_W   = 8;
   // Filter control byte fields
   localparam int CTL_ON_BIT   = 7;
   localparam int CTL_MSEL_LSB = 5;
   localparam int CTL_DEST_LSB = 0;
   // Filter value and mask word fields
   localparam int VAL_SID_LSB = 21;
   localparam int VAL_EXT_BIT = 19;
   localparam int VAL_EID_LSB = 0;
   localparam logic [31:0] VAL_USED = 32'hffebffff;
   // Status word fields
   localparam int STAT_DEST_LSB = 0;
   localparam int STAT_HIT_LSB  = 8;
   localparam int STAT_OK_BIT   = 15;
   localparam int STAT_BUSY_BIT = 16;
   localparam int STAT_MODE_LSB = 24;
   // Operating modes
   localparam logic [2:0] MODE_NORMAL  = 3'h0;
   localparam logic [2:0] MODE_DISABLE = 3'h1;
   localparam logic [2:0] MODE_CONFIG  = 3'h4;
   // Byte addresses
   localparam logic [7:0] ADDR_CTL     = 8'h00;
   localparam logic [7:0] ADDR_CTL_END = 8'h20;
   localparam logic [7:0] ADDR_VAL     = 8'h40;
   localparam logic [7:0] ADDR_MASK    = 8'hc0;
   localparam logic [7:0] ADDR_STAT    = 8'hd0;
   localparam logic [7:0] ADDR_ACC     = 8'hd4;
   localparam logic [7:0] ADDR_DROP    = 8'hd8;
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DONE} cafu_state_t;
   typedef enum logic [2:0] {
      RG_CTL, RG_VAL, RG_MASK, RG_STAT, RG_ACC, RG_DROP, RG_NONE
   } cafu_region_t;
endpackage

// ==== bench/cafu_asm_model.sv ====
module cafu_asm_model (
   input  wire logic                        clk,
   input  wire logic                        arst_n,
   input  wire logic                        frmGo,
   input  wire logic [cafu_pkg::SID_W-1:0]  frmSid,
   input  wire logic [cafu_pkg::EID_W-1:0]  frmEid,
   input  wire logic                        frmExt,
   input  wire logic                        asmReady,
   output logic                             asmValid,
   output logic [cafu_pkg::SID_W-1:0]       asmStdId,
   output logic [cafu_pkg::EID_W-1:0]       asmExtId,
   output logic                             asmIsExt
);
   timeunit 1ns;
   timeprecision 1ns;
   import cafu_pkg::*;

   // Offer a frame, hold it until taken, then scramble the released lines
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         asmValid <= 1'b0;
         asmStdId <= '1;
         asmExtId <= '1;
         asmIsExt <= 1'b1;
      end else if (frmGo) begin
         asmValid <= 1'b1;
         asmStdId <= frmSid;   // Standard identifier part
         asmExtId <= frmEid;
         asmIsExt <= frmExt;
      end else if (asmValid && asmReady) begin
         asmValid <= 1'b0;
         asmStdId <= ~asmStdId;
         asmExtId <= ~asmExtId;
         asmIsExt <= ~asmIsExt;
      end
   end
endmodule

// ==== bench/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cafu_pkg::*;

   logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, asmValid, asmReady, asmIsExt;
   logic storeValid, dropValid, frmGo, frmExt;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, fifoFull;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [2:0]  opMode;
   logic [10:0] asmStdId, frmSid;
   logic [17:0] asmExtId, frmEid;
   logic [4:0]  storeFifo, filterHitIndex;
   int          n_fail, comparisons;

   cafu_filter_unit u_cafu_filter_unit (.clk(clk), .arst_n(arst_n),
      .ce(1'b1), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .operatingModeStatus(opMode),
      .asmValid(asmValid), .asmReady(asmReady), .asmStdId(asmStdId),
      .asmExtId(asmExtId), .asmIsExt(asmIsExt), .fifoFull(fifoFull),
      .storeValid(storeValid), .storeFifo(storeFifo),
      .filterHitIndex(filterHitIndex), .dropValid(dropValid));

   cafu_asm_model u_cafu_asm_model (.clk(clk), .arst_n(arst_n),
      .frmGo(frmGo), .frmSid(frmSid), .frmEid(frmEid), .frmExt(frmExt),
      .asmReady(asmReady), .asmValid(asmValid), .asmStdId(asmStdId),
      .asmExtId(asmExtId), .asmIsExt(asmIsExt));

   // Clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, g, x);
      end
   endtask

   // Value or mask word: standard part, type bit 19, extended part
   function automatic logic [31:0] vw(logic [10:0] s, logic x,
                                      logic [17:0] e);
      return {s, 1'b0, x, 1'b0, e};
   endfunction

   // Bus write; ready sampled before the edge it qualifies
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      // bready stays high so a following write never toggles it twice
      chk(r, er);
   endtask

   // Bus read with expected data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic ar, v;
      logic [31:0] d;
      logic [1:0] r;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge clk);
         ar = arvalid & arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end
      // rready stays high so a following read never toggles it twice
      chk(d, ed);
      chk(r, er);
   endtask

   // Offer one frame and judge the single store or drop that follows
   task automatic frame(input logic [10:0] s, input logic [17:0] e,
                        input logic x, input logic st,
                        input logic [4:0] f, input logic [4:0] h);
      int ns, nd;
      logic [4:0] gf, gh;
      ns = 0; nd = 0; gf = '0; gh = '0;
      frmSid <= s; frmEid <= e; frmExt <= x; frmGo <= 1'b1;
      @(posedge clk);
      frmGo <= 1'b0;
      repeat (40) begin
         @(negedge clk);
         if (storeValid === 1'b1) begin
            ns++; gf = storeFifo; gh = filterHitIndex;
         end
         if (dropValid === 1'b1) nd++;
      end
      @(posedge clk);
      chk(ns, st);
      chk(nd, !st);
      if (st) begin
         chk(gf, f);
         chk(gh, h);
      end
   endtask

   // Priority, full FIFOs, masking and discards on filters 1 to 4
   task automatic t_priority;
      opMode <= MODE_CONFIG;
      rd(8'h00, 32'h0, RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(8'he0, 32'h1, 4'hf, RESP_SLVERR);
      wr(8'hc4, vw(11'h7fc, 1'b1, 18'h0), 4'hf, RESP_OKAY);
      for (int i = 1; i < 5; i++)
         wr(8'h40 + 8'(4 * i), vw(11'h100, 1'b0, 18'h0), 4'hf, RESP_OKAY);
      wr(8'h00, 32'ha5a9a900, 4'hf, RESP_OKAY);
      wr(8'h04, 32'h000000a4, 4'h1, RESP_OKAY);
      rd(8'h00, 32'ha5a9a900, RESP_OKAY);
      fifoFull <= 32'h0;
      frame(11'h102, 18'h0, 1'b0, 1'b1, 5'd9, 5'd1);
      fifoFull <= 32'h200;
      frame(11'h101, 18'h0, 1'b0, 1'b1, 5'd5, 5'd3);
      fifoFull <= 32'h220;
      frame(11'h103, 18'h0, 1'b0, 1'b1, 5'd4, 5'd4);
      fifoFull <= 32'h230;
      frame(11'h100, 18'h0, 1'b0, 1'b0, 5'd0, 5'd0);
      fifoFull <= 32'h0;
      frame(11'h104, 18'h0, 1'b0, 1'b0, 5'd0, 5'd0);
      frame(11'h100, 18'h0, 1'b1, 1'b0, 5'd0, 5'd0);
   endtask

   // Locked value and mask writes, mode gates, switching filters off
   task automatic t_locks;
      logic [2:0] m [4];
      m = '{MODE_NORMAL, MODE_DISABLE, MODE_CONFIG, 3'h2};
      wr(8'h4c, vw(11'h200, 1'b0, 18'h0), 4'hf, RESP_OKAY);
      rd(8'h4c, vw(11'h100, 1'b0, 18'h0), RESP_OKAY);
      wr(8'hc4, 32'h0, 4'hf, RESP_OKAY);
      rd(8'hc4, vw(11'h7fc, 1'b1, 18'h0), RESP_OKAY);
      opMode <= MODE_NORMAL;
      wr(8'hc8, vw(11'h7ff, 1'b0, 18'h3ffff), 4'hf, RESP_OKAY);
      rd(8'hc8, 32'h0, RESP_OKAY);
      opMode <= MODE_CONFIG;
      wr(8'hc8, vw(11'h7ff, 1'b0, 18'h3ffff), 4'hf, RESP_OKAY);
      rd(8'hc8, vw(11'h7ff, 1'b0, 18'h3ffff), RESP_OKAY);
      wr(8'h00, 32'h0, 4'hf, RESP_OKAY);
      wr(8'h04, 32'h0, 4'h1, RESP_OKAY);
      rd(8'h00, 32'h0, RESP_OKAY);
      frame(11'h102, 18'h0, 1'b0, 1'b0, 5'd0, 5'd0);
      for (int i = 0; i < 4; i++) begin
         opMode <= m[i];
         wr(8'h04, {8'h0, 8'(i + 1), 16'h0}, 4'h4, RESP_OKAY);
         rd(8'h04, {8'h0, 8'(i < 3 ? i + 1 : 3), 16'h0}, RESP_OKAY);
      end
   endtask

   // Type handling on filter 5 with mask 2
   task automatic t_types;
      opMode <= MODE_CONFIG;
      wr(8'h54, vw(11'h055, 1'b1, 18'h1c498), 4'hf, RESP_OKAY);
      wr(8'h04, 32'h0000cc00, 4'h2, RESP_OKAY);
      frame(11'h055, 18'h0, 1'b0, 1'b1, 5'd12, 5'd5);
      frame(11'h055, 18'h1c498, 1'b1, 1'b1, 5'd12, 5'd5);
      frame(11'h055, 18'h1c499, 1'b1, 1'b0, 5'd0, 5'd0);
      wr(8'h04, 32'h0, 4'h2, RESP_OKAY);
      wr(8'hc8, vw(11'h7ff, 1'b1, 18'h3ffff), 4'hf, RESP_OKAY);
      wr(8'h04, 32'h0000cc00, 4'h2, RESP_OKAY);
      frame(11'h055, 18'h0, 1'b0, 1'b0, 5'd0, 5'd0);
      frame(11'h055, 18'h1c498, 1'b1, 1'b1, 5'd12, 5'd5);
   endtask

   // Switching filter 31 off while a frame that hits it is scanned
   task automatic t_defer;
      wr(8'hc0, vw(11'h7ff, 1'b0, 18'h0), 4'hf, RESP_OKAY);
      wr(8'hbc, vw(11'h3aa, 1'b0, 18'h0), 4'hf, RESP_OKAY);
      wr(8'h1c, 32'h9f000000, 4'h8, RESP_OKAY);
      opMode <= MODE_NORMAL;
      fork
         frame(11'h3aa, 18'h0, 1'b0, 1'b1, 5'd31, 5'd31);
         begin
            repeat (4) @(posedge clk);
            wr(8'h1c, 32'h1f000000, 4'h8, RESP_OKAY);
            rd(8'h1c, 32'h9f000000, RESP_OKAY);
         end
      join
      rd(8'h1c, 32'h1f000000, RESP_OKAY);
      // Last result: FIFO 31, hit 31, accepted, idle, normal mode
      rd(8'hd0, 32'h00009f1f, RESP_OKAY);
      rd(8'hd4, 32'h00000007, RESP_OKAY);
      rd(8'hd8, 32'h00000006, RESP_OKAY);
   endtask

   // Main sequence
   initial begin
      n_fail = 0; comparisons = 0;
      arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0;
      wdata = '0; wstrb = '0; opMode = MODE_CONFIG; fifoFull = '0;
      frmGo = 1'b0; frmSid = '0; frmEid = '0; frmExt = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_priority();
      t_locks();
      t_types();
      t_defer();
      end_of_test();
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
endmodule
